// file: core/scsp_defs.svh
// Register address, field positions, reset value and bus timing of the SMBus control port
`ifndef SCSP_DEFS_SVH
`define SCSP_DEFS_SVH
// Summary of operation
// - Bit 7 reads 1 as master, 0 slave.
// - Bit 6 reads 1 transmitting, 0 receiving.
// - Bit 5 reads 1 after start detected.
// - Writing bit 5 high starts master; restarts it after start or sent byte.
// - Bit 4 reads stop detected or stop pending.
// - Bit 4 high sends stop, then self-clears.
// - Bit 3 reads 1 when acknowledge decision needed.
// - Bit 2 reads 1 after arbitration lost.
// - Bit 1 reads received acknowledge or not.
// - Written bit 1 chooses next sent acknowledge.
// - Bus events set bit 0; holds SCL low.
// - Write 0 clears bit 0; 1 forces it.
// - Whole register reads zero after reset.
`define SCSP_CTRL_ADDR   8'hC0
`define SCSP_CTRL_RESET  8'h00
`define SCSP_BIT_ROLE    7
`define SCSP_BIT_DIR     6
`define SCSP_BIT_BEGIN   5
`define SCSP_BIT_HALT    4
`define SCSP_BIT_RESPREQ 3
`define SCSP_BIT_ARBITRATION_LOST_FLAG 2
`define SCSP_BIT_RESP    1
`define SCSP_BIT_EVENT   0
`define SCSP_ACK_SLOT    4'h8
`define SCSP_BYTE_DONE   4'h9
`define SCSP_CLK_MHZ     250
`define SCSP_HALF_NS     5000
`define SCSP_HALF_CYC    ((`SCSP_HALF_NS * `SCSP_CLK_MHZ + 999) / 1000)
`endif

// file: core/scsp_pkg.sv
// Types shared by the SMBus control port
package scsp_pkg;
	typedef enum logic [2:0] {
		scsp_m_idle   = 3'b000,
		scsp_m_start  = 3'b001,
		scsp_m_run    = 3'b010,
		scsp_m_rstart = 3'b011,
		scsp_m_stop1  = 3'b100,
		scsp_m_stop2  = 3'b101
	} scsp_mst_type;
	typedef struct packed {
		logic master;
		logic direction_indicator;
		logic begin_condition_flag;
		logic halt_condition_flag;
		logic response_request_flag;
		logic arbitration_lost_flag;
		logic ack;
		logic si;
	} scsp_ctrl_type;
endpackage : scsp_pkg

// file: core/scsp_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
module scsp_sync #(
	parameter int WIDTH = 2
) (
	// Clock and reset
	input  wire logic             sys_clk,
	input  wire logic             rst,
	input  wire logic             ce,
	// Pins and synchronised copy
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage1;

	// Idle bus lines are high, so reset to released
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			stage1   <= '1;
			sync_out <= '1;
		end else if (ce) begin
			stage1   <= async_in;
			sync_out <= stage1;
		end
	end
endmodule : scsp_sync

// file: core/scsp_top.sv
// SMBus control and status port with its bit engine
`timescale 1ns/1ps
`include "scsp_defs.svh"
module scsp_top
	import scsp_pkg::*;
#(
	parameter int HALF_CYC = `SCSP_HALF_CYC
) (
	// Clock, reset, enable
	input  wire logic       sys_clk,
	input  wire logic       rst,
	input  wire logic       ce,
	// Special-function register port
	input  wire logic [7:0] sfr_addr,
	input  wire logic       sfr_wr,
	input  wire logic [7:0] sfr_wdata,
	output logic      [7:0] sfr_rdata,
	// Byte data
	input  wire logic [7:0] tx_byte,
	output logic      [7:0] rx_byte,
	// Open-drain bus pins
	input  wire logic       scl_in,
	output logic            scl_out,
	output logic            scl_oe_n,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe_n
);
	scsp_ctrl_type ctrl, next_ctrl;
	scsp_mst_type  st, next_st;
	logic [1:0]  sync_pins;
	logic        s_scl, s_sda, p_scl, p_sda;
	logic [7:0]  shift, next_shift, next_rx_byte, next_rdata;
	logic [3:0]  bit_cnt, next_bit_cnt;
	logic [15:0] cnt, next_cnt;
	logic        sta_req, next_sta_req, active, next_active, first, next_first;
	logic        scl_low, next_scl_low, sda_low_m, next_sda_low_m, sda_low_d, next_sda_low_d;
	logic        wr_hit, si_release, scl_rise, scl_fall, start_det, stop_det;
	logic        half_done, bus_free, start_go, arb_hit;

	scsp_sync #(.WIDTH(2)) u_sync (
		.sys_clk  (sys_clk),
		.rst      (rst),
		.ce       (ce),
		.async_in ({scl_in, sda_in}),
		.sync_out (sync_pins)
	);

	assign s_scl      = sync_pins[1];
	assign s_sda      = sync_pins[0];
	assign wr_hit     = sfr_wr && (sfr_addr == `SCSP_CTRL_ADDR);
	assign si_release = wr_hit && ctrl.si && !sfr_wdata[`SCSP_BIT_EVENT];
	assign scl_rise   = s_scl && !p_scl;
	assign scl_fall   = !s_scl && p_scl;
	assign start_det  = p_scl && s_scl && p_sda && !s_sda;
	assign stop_det   = p_scl && s_scl && !p_sda && s_sda;
	assign half_done  = (cnt == 16'(HALF_CYC - 1));
	assign bus_free   = !active && !ctrl.master && s_scl && s_sda;
	assign start_go   = (st == scsp_m_idle) && sta_req && bus_free;
	// Another master pulled SDA low while this one released it
	assign arb_hit    = scl_rise && active && ctrl.master && ctrl.direction_indicator && (st == scsp_m_run)
	                    && (bit_cnt < `SCSP_ACK_SLOT) && !sda_low_d && !s_sda;

	always_comb begin
		next_ctrl      = ctrl;
		next_st        = st;
		next_shift     = shift;
		next_rx_byte   = rx_byte;
		next_bit_cnt   = bit_cnt;
		next_cnt       = cnt;
		next_sta_req   = sta_req;
		next_active    = active;
		next_first     = first;
		next_scl_low   = scl_low;
		next_sda_low_m = sda_low_m;
		next_sda_low_d = sda_low_d;
		if (wr_hit) begin
			next_ctrl.begin_condition_flag = sfr_wdata[`SCSP_BIT_BEGIN];
			next_sta_req  = sfr_wdata[`SCSP_BIT_BEGIN];
			next_ctrl.halt_condition_flag = sfr_wdata[`SCSP_BIT_HALT];
			next_ctrl.ack = sfr_wdata[`SCSP_BIT_RESP];
			next_ctrl.si  = sfr_wdata[`SCSP_BIT_EVENT];
		end
		// Releasing the event flag acts on the settings written with it
		if (si_release) begin
			next_ctrl.response_request_flag = 1'b0;
			if (ctrl.response_request_flag && !ctrl.direction_indicator) begin
				next_sda_low_d = next_ctrl.ack;
			end else if (ctrl.master && bit_cnt == 4'h0 && next_ctrl.halt_condition_flag) begin
				// A data bit left driven after a start event would block the stop edge
				next_st        = scsp_m_stop1;
				next_cnt       = 16'h0000;
				next_sda_low_d = 1'b0;
			end else if (ctrl.master && bit_cnt == 4'h0 && next_sta_req) begin
				next_st        = scsp_m_rstart;
				next_cnt       = 16'h0000;
				next_sda_low_d = 1'b0;
			end else if (ctrl.direction_indicator && bit_cnt == 4'h0) begin
				next_shift     = tx_byte;
				next_sda_low_d = !tx_byte[7];
			end
		end
		case (st)
			scsp_m_idle: begin
				if (start_go) begin
					next_st  = scsp_m_start;
					next_cnt = 16'h0000;
				end
			end
			scsp_m_start: begin
				next_cnt = cnt + 16'h0001;
				if (!sda_low_m) begin
					if (!s_scl) begin
						next_cnt = 16'h0000;
					end else if (half_done) begin
						next_sda_low_m = 1'b1;
						next_cnt       = 16'h0000;
					end
				end else if (half_done) begin
					next_st          = scsp_m_run;
					next_cnt         = 16'h0000;
					next_scl_low     = 1'b1;
					next_ctrl.master = 1'b1;
					next_ctrl.direction_indicator = 1'b1;
					next_ctrl.si     = 1'b1;
					next_ctrl.arbitration_lost_flag = 1'b0;
					next_sta_req     = 1'b0;
				end
			end
			scsp_m_run: begin
				// The event flag freezes the clock generator, so SCL stays low
				if (!ctrl.si) begin
					if (scl_low || s_scl) begin
						next_cnt = cnt + 16'h0001;
					end
					if (half_done) begin
						next_scl_low = !scl_low;
						next_cnt     = 16'h0000;
					end
				end
			end
			scsp_m_rstart: begin
				next_cnt = cnt + 16'h0001;
				if (half_done) begin
					next_scl_low = 1'b0;
					next_st      = scsp_m_start;
					next_cnt     = 16'h0000;
				end
			end
			scsp_m_stop1: begin
				next_cnt       = cnt + 16'h0001;
				next_sda_low_m = 1'b1;
				if (half_done) begin
					next_scl_low = 1'b0;
					next_st      = scsp_m_stop2;
					next_cnt     = 16'h0000;
				end
			end
			scsp_m_stop2: begin
				// Waits out clock stretching before the stop edge
				if (s_scl) begin
					next_cnt = cnt + 16'h0001;
				end
				if (half_done) begin
					next_sda_low_m = 1'b0;
					next_st        = scsp_m_idle;
					next_cnt       = 16'h0000;
				end
			end
			default: next_st = scsp_m_idle;
		endcase
		if (scl_rise && active) begin
			if (bit_cnt < `SCSP_ACK_SLOT) begin
				next_shift = {shift[6:0], s_sda};
			end else if (bit_cnt == `SCSP_ACK_SLOT && ctrl.direction_indicator) begin
				next_ctrl.ack = !s_sda;
			end
			next_bit_cnt = bit_cnt + 4'h1;
		end
		if (scl_fall && active) begin
			next_sda_low_m = 1'b0;
			if (bit_cnt == `SCSP_ACK_SLOT) begin
				next_sda_low_d = 1'b0;
				if (!ctrl.direction_indicator) begin
					next_ctrl.si    = 1'b1;
					next_ctrl.response_request_flag = 1'b1;
					next_rx_byte    = shift;
				end
			end else if (bit_cnt == `SCSP_BYTE_DONE) begin
				next_bit_cnt   = 4'h0;
				next_sda_low_d = 1'b0;
				next_first     = 1'b0;
				if (first) begin
					next_ctrl.direction_indicator = ctrl.master ? !shift[0] : shift[0];
				end
				if (ctrl.master && ctrl.halt_condition_flag) begin
					next_st  = scsp_m_stop1;
					next_cnt = 16'h0000;
				end else if (ctrl.direction_indicator || next_ctrl.direction_indicator) begin
					next_ctrl.si = 1'b1;
				end
			end else begin
				next_sda_low_d = ctrl.direction_indicator && !shift[7];
			end
		end
		if (start_det) begin
			next_ctrl.begin_condition_flag  = 1'b1;
			next_active    = 1'b1;
			next_first     = 1'b1;
			next_bit_cnt   = 4'h0;
			next_sda_low_d = 1'b0;
			if (!ctrl.master) begin
				next_ctrl.direction_indicator = 1'b0;
			end
		end
		if (stop_det) begin
			next_active    = 1'b0;
			next_bit_cnt   = 4'h0;
			next_sda_low_d = 1'b0;
			if (ctrl.master) begin
				next_ctrl.master = 1'b0;
				next_ctrl.halt_condition_flag    = 1'b0;
			end else begin
				next_ctrl.halt_condition_flag = 1'b1;
				next_ctrl.si  = 1'b1;
			end
		end
		if (arb_hit) begin
			next_ctrl.master  = 1'b0;
			next_ctrl.arbitration_lost_flag = 1'b1;
			next_ctrl.si      = 1'b1;
			next_st           = scsp_m_idle;
			next_scl_low      = 1'b0;
			next_sda_low_d    = 1'b0;
		end
		next_rdata = (sfr_addr == `SCSP_CTRL_ADDR) ? next_ctrl : 8'h00;
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ctrl      <= `SCSP_CTRL_RESET;
			st        <= scsp_m_idle;
			shift     <= 8'h00;
			rx_byte   <= 8'h00;
			bit_cnt   <= 4'h0;
			cnt       <= 16'h0000;
			sta_req   <= 1'b0;
			active    <= 1'b0;
			first     <= 1'b0;
			scl_low   <= 1'b0;
			sda_low_m <= 1'b0;
			sda_low_d <= 1'b0;
			p_scl     <= 1'b1;
			p_sda     <= 1'b1;
			sfr_rdata <= 8'h00;
			scl_oe_n  <= 1'b1;
			sda_oe_n  <= 1'b1;
			scl_out   <= 1'b0;
			sda_out   <= 1'b0;
		end else if (ce) begin
			ctrl      <= next_ctrl;
			st        <= next_st;
			shift     <= next_shift;
			rx_byte   <= next_rx_byte;
			bit_cnt   <= next_bit_cnt;
			cnt       <= next_cnt;
			sta_req   <= next_sta_req;
			active    <= next_active;
			first     <= next_first;
			scl_low   <= next_scl_low;
			sda_low_m <= next_sda_low_m;
			sda_low_d <= next_sda_low_d;
			p_scl     <= s_scl;
			p_sda     <= s_sda;
			sfr_rdata <= next_rdata;
			scl_oe_n  <= !(next_ctrl.si || next_scl_low);
			sda_oe_n  <= !(next_sda_low_d || next_sda_low_m);
			scl_out   <= 1'b0;
			sda_out   <= 1'b0;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	a_reset_zero: assert property ($past(rst) |-> ctrl == 8'h00 && scl_oe_n) else $error("register not zero after reset");
	a_role_readonly: assert property (ce && wr_hit && !stop_det && !arb_hit && st != scsp_m_start
		|=> ctrl.master == $past(ctrl.master)) else $error("role bit changed by a write");
	a_dir_readonly: assert property (ce && wr_hit && !start_det && !scl_fall && st != scsp_m_start
		|=> ctrl.direction_indicator == $past(ctrl.direction_indicator)) else $error("direction bit changed by a write");
	a_start_flag: assert property (ce && start_det |=> ctrl.begin_condition_flag) else $error("start not flagged");
	a_start_request: assert property (ce && start_go |=> st == scsp_m_start) else $error("start request ignored");
	a_stop_flag: assert property (ce && stop_det && !ctrl.master |=> ctrl.halt_condition_flag && ctrl.si) else $error("slave stop not flagged");
	a_stop_clears: assert property (ce && stop_det && ctrl.master |=> !ctrl.halt_condition_flag && !ctrl.master) else $error("stop flag not cleared");
	a_response_request_flag_pending: assert property (ctrl.response_request_flag |-> ctrl.si) else $error("ack request without event flag");
	a_arb_lost: assert property (ce && arb_hit |=> ctrl.arbitration_lost_flag && ctrl.si && !ctrl.master) else $error("arbitration loss missed");
	a_ack_received: assert property (ce && scl_rise && active && bit_cnt == `SCSP_ACK_SLOT && ctrl.direction_indicator
		|=> ctrl.ack == !$past(s_sda)) else $error("received acknowledge wrong");
	a_ack_sent: assert property (ce && si_release && ctrl.response_request_flag && !ctrl.direction_indicator && !stop_det && !start_det
		|=> sda_oe_n == !$past(sfr_wdata[`SCSP_BIT_RESP])) else $error("sent acknowledge wrong");
	a_event_stall: assert property (ctrl.si && !si_release && st == scsp_m_run && ce
		|=> $stable(cnt) && !scl_oe_n) else $error("bus not stalled by event flag");
	a_event_force: assert property (ce && wr_hit && sfr_wdata[`SCSP_BIT_EVENT] |=> ctrl.si ##1 !scl_oe_n || !ce)
		else $error("forced event not taken");
	c_master_start: cover property (st == scsp_m_start ##[1:1000] st == scsp_m_run);
	c_arb_lost: cover property (arb_hit);
	c_slave_stop: cover property (stop_det && !ctrl.master);
	c_ack_request: cover property ($rose(ctrl.response_request_flag));
endmodule : scsp_top

// file: bench/scsp_bus_peer.sv
// Behavioural SMBus slave and line-holding peer facing the control port
`timescale 1ns/1ps
module scsp_bus_peer (
	// Wired bus levels
	input  wire logic       scl,
	input  wire logic       sda,
	// Bench controls
	input  wire logic       nack,
	input  wire logic       hold_sda,
	input  wire logic [7:0] rd_data,
	// Pull-down and observations
	output logic            sda_low,
	output logic [7:0]      got_byte,
	output logic            got_ack,
	output int              stops
);
	int   bitn    = -1;
	int   nbyte   = 0;
	logic rd      = 1'b0;
	logic ack_drv = 1'b0;
	logic dat_drv = 1'b0;
	// Open drain: a released line floats to the pull-up, never to the last value
	assign sda_low = ack_drv | dat_drv | hold_sda;
	initial stops = 0;
	always @(negedge sda) if (scl === 1'b1) begin
		bitn = 0;
		nbyte = 0;
		rd = 1'b0;
	end
	always @(posedge sda) if (scl === 1'b1) begin
		stops++;
		bitn = -1;
	end
	always @(posedge scl) if (bitn >= 0) begin
		if (bitn < 8) got_byte = {got_byte[6:0], sda};
		else got_ack = ~sda;
		if (bitn == 8 && nbyte == 0) rd = got_byte[0];
		if (bitn == 8) nbyte++;
		bitn = (bitn == 8) ? 0 : bitn + 1;
	end
	// Stop sending read data once the master refuses a byte
	always @(negedge scl) begin
		ack_drv <= 1'b0;
		dat_drv <= 1'b0;
		if (bitn == 8 && (nbyte == 0 || !rd)) ack_drv <= ~nack;
		else if (bitn >= 0 && bitn < 8 && rd && got_ack) dat_drv <= ~rd_data[7 - bitn];
	end
endmodule : scsp_bus_peer

// file: bench/test_scsp_top.sv
// Self-checking bench for the SMBus control and status port
`timescale 1ns/1ps
module test_scsp_top;
	// Four cycles a half gives the 32 ns link clock
	localparam int         HALF       = 4;
	localparam logic [7:0] R_ADDR [5] = '{8'hC0, 8'hC0, 8'hC0, 8'hC1, 8'hC0};
	localparam logic [7:0] R_DATA [5] = '{8'hCC, 8'h02, 8'h03, 8'hFF, 8'h00};
	localparam logic [7:0] R_EXP  [5] = '{8'h00, 8'h02, 8'h03, 8'h03, 8'h00};
	logic       sys_clk    = 1'b0;
	logic       rst        = 1'b1;
	logic [7:0] sfr_addr   = 8'hC0;
	logic       sfr_wr     = 1'b0;
	logic [7:0] sfr_wdata  = 8'h00;
	logic [7:0] tx_byte    = 8'h00;
	logic       nack       = 1'b0;
	logic       hold_sda   = 1'b0;
	logic [7:0] sfr_rdata;
	logic [7:0] rx_byte;
	logic       scl_oe_n;
	logic       sda_oe_n;
	logic       sda_low;
	logic [7:0] got_byte;
	logic       got_ack;
	int         stops;
	int         s0;
	int         fail_count = 0;
	int         n_compared = 0;
	wire        scl_w      = scl_oe_n;
	wire        sda_w      = sda_oe_n & ~sda_low;
	always #2 sys_clk = ~sys_clk;
	scsp_top #(.HALF_CYC(HALF)) dut (.sys_clk(sys_clk), .rst(rst), .ce(1'b1),
		.sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
		.tx_byte(tx_byte), .rx_byte(rx_byte), .scl_in(scl_w), .scl_out(),
		.scl_oe_n(scl_oe_n), .sda_in(sda_w), .sda_out(), .sda_oe_n(sda_oe_n));
	scsp_bus_peer peer (.scl(scl_w), .sda(sda_w), .nack(nack), .hold_sda(hold_sda),
		.rd_data(8'h5A), .sda_low(sda_low), .got_byte(got_byte), .got_ack(got_ack),
		.stops(stops));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		sfr_addr = a;
		sfr_wdata = d;
		sfr_wr = 1'b1;
		@(negedge sys_clk);
		sfr_wr = 1'b0;
		sfr_addr = 8'hC0;
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
		@(negedge sys_clk);
		sfr_addr = a;
		@(negedge sys_clk);
		chk(sfr_rdata & m, e & m);
		sfr_addr = 8'hC0;
	endtask : rd
	task automatic wait_bit(input int idx, input logic val);
		int i;
		for (i = 0; i < 600 && sfr_rdata[idx] !== val; i++) @(negedge sys_clk);
		chk({7'h0, sfr_rdata[idx]}, {7'h0, val});
	endtask : wait_bit
	task automatic end_of_test();
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : end_of_test
	initial begin
		#100000;
		fail_count++;
		end_of_test();
	end
	initial begin
		repeat (4) @(negedge sys_clk);
		rst = 1'b0;
		rd(8'hC0, 8'h00, 8'hFF);
		chk({6'h0, scl_oe_n, sda_oe_n}, 8'h03);
		for (int i = 0; i < 5; i++) begin
			wr(R_ADDR[i], R_DATA[i]);
			rd(8'hC0, R_EXP[i], 8'hFF);
			chk({7'h0, scl_oe_n}, {7'h0, ~R_EXP[i][0]});
		end
		rd(8'hC1, 8'h00, 8'hFF);
		$display("test register rows done");
		for (int k = 0; k < 2; k++) begin
			nack = k[0];
			s0 = stops;
			wr(8'hC0, 8'h20);
			wait_bit(0, 1'b1);
			rd(8'hC0, 8'hE1, 8'hFD);
			repeat (20) @(negedge sys_clk);
			chk({7'h0, scl_oe_n}, 8'h00);
			tx_byte = 8'hA4;
			wr(8'hC0, 8'h00);
			wait_bit(0, 1'b1);
			chk(got_byte, 8'hA4);
			rd(8'hC0, (k == 1) ? 8'hC1 : 8'hC3, 8'hCF);
			wr(8'hC0, 8'h10);
			rd(8'hC0, 8'h90, 8'h90);
			wait_bit(7, 1'b0);
			rd(8'hC0, 8'h00, 8'h91);
			chk(8'(stops - s0), 8'h01);
			$display("test master write nack=%0d done", k);
		end
		nack = 1'b0;
		// Repeated start at a byte boundary, then a stop straight from its event
		s0 = stops;
		wr(8'hC0, 8'h20);
		wait_bit(0, 1'b1);
		wr(8'hC0, 8'h00);
		wait_bit(0, 1'b1);
		wr(8'hC0, 8'h20);
		wait_bit(0, 1'b1);
		rd(8'hC0, 8'hE1, 8'hFD);
		chk(8'(stops - s0), 8'h00);
		wr(8'hC0, 8'h10);
		wait_bit(7, 1'b0);
		chk(8'(stops - s0), 8'h01);
		$display("test repeated start done");
		wr(8'hC0, 8'h20);
		wait_bit(0, 1'b1);
		tx_byte = 8'hA5;
		wr(8'hC0, 8'h00);
		wait_bit(0, 1'b1);
		wr(8'hC0, 8'h00);
		wait_bit(0, 1'b1);
		rd(8'hC0, 8'h89, 8'hCD);
		chk(rx_byte, 8'h5A);
		wr(8'hC0, 8'h10);
		wait_bit(7, 1'b0);
		chk({7'h0, got_ack}, 8'h00);
		$display("test master read done");
		hold_sda = 1'b1;
		repeat (8) @(negedge sys_clk);
		rd(8'hC0, 8'h20, 8'hA0);
		hold_sda = 1'b0;
		wait_bit(0, 1'b1);
		rd(8'hC0, 8'h11, 8'h91);
		wr(8'hC0, 8'h00);
		$display("test slave start stop done");
		wr(8'hC0, 8'h20);
		wait_bit(0, 1'b1);
		tx_byte = 8'hFF;
		hold_sda = 1'b1;
		wr(8'hC0, 8'h00);
		wait_bit(0, 1'b1);
		rd(8'hC0, 8'h05, 8'h85);
		// Release SDA while SCL is still held so no stop is seen
		hold_sda = 1'b0;
		rst = 1'b1;
		repeat (4) @(negedge sys_clk);
		rst = 1'b0;
		rd(8'hC0, 8'h00, 8'hFF);
		$display("test arbitration and mid-run reset done");
		end_of_test();
	end
endmodule : test_scsp_top
